// File: verilog/qqd_decoder.sv
// Quad and QPI instruction decoder of a serial NOR flash, host pins sampled on mclk
`timescale 1ns/1ps
// Function
// - 6Bh: address, dummy, then quad read data
// - 33h: address, then quad program data bytes
// - QPI: every byte two clocks, four lines
// - QPI 50h alone sets volatile write enable
// - QPI 35h drives upper status byte out
// - QPI 31h writes one upper status byte
// - Chip select rising completes the instruction
// - Writes need whole bytes, else discarded
// - While busy only status read accepted
`include "qqd_regs.svh"
module qqd_decoder
  import qqd_pkg::*;
#(
  parameter int ADDR_W = `QQD_ADDR_BITS
)
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Host pins
  input  wire logic              csN,
  input  wire logic              sclk,
  input  wire logic [3:0]        ioIn,
  output logic      [3:0]        ioOut,
  output logic      [3:0]        ioOe,
  // Mode and status
  input  wire logic              qpiMode,
  input  wire logic              busy,
  output logic      [7:0]        statusUpper,
  output logic                   statusWr,
  output logic                   vsrWe,
  // Array read
  output logic                   rdReq,
  output logic      [ADDR_W-1:0] rdAddr,
  input  wire logic [7:0]        rdData,
  // Array program
  output logic                   pgmStb,
  output logic      [ADDR_W-1:0] pgmAddr,
  output logic      [7:0]        pgmData,
  output logic                   pgmDone,
  output logic                   pgmAbort
);

  // Address must be two or three whole bytes
  if (ADDR_W % 8 != 0 || ADDR_W < 16 || ADDR_W > 24)
  begin : g_chk
    $error("ADDR_W must be 16 or 24");
  end

  localparam logic [1:0] LAST_ADDR = 2'(ADDR_W / 8 - 1);

  qqd_state_t        st_r, st_nxt;
  logic              csPrev_r, sclkPrev_r;
  logic [7:0]        cmd_r, cmd_nxt, sh_r, sh_nxt;
  logic [7:0]        srByte_r, srByte_nxt, rdByte_r, rdByte_nxt;
  logic [2:0]        bitCnt_r, bitCnt_nxt;
  logic [1:0]        byteCnt_r, byteCnt_nxt;
  logic              nibLo_r, nibLo_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt, pgmAddr_r, pgmAddr_nxt;
  logic [3:0]        ioOut_r, ioOut_nxt, ioOe_r, ioOe_nxt;
  logic [7:0]        statusUpper_r, statusUpper_nxt, pgmData_r, pgmData_nxt;
  logic              statusWr_r, statusWr_nxt, vsrWe_r, vsrWe_nxt;
  logic              rdReq_r, rdReq_nxt, pgmStb_r, pgmStb_nxt;
  logic              pgmDone_r, pgmDone_nxt, pgmAbort_r, pgmAbort_nxt;
  logic              sclkRise, sclkFall, csRise, lanes4, byteDone, opDone;
  logic [3:0]        bitSum;
  logic [7:0]        shNew;

  // Pin edges; pins are synchronous to mclk so no synchroniser is needed
  assign sclkRise = sclk & ~sclkPrev_r & ~csN;
  assign sclkFall = ~sclk & sclkPrev_r & ~csN;
  assign csRise   = csN & ~csPrev_r;
  // Program data always uses four lines, everything in QPI too
  assign lanes4   = qpiMode | (st_r == ST_WDATA);
  assign bitSum   = {1'b0, bitCnt_r} + (lanes4 ? `QQD_LANES_FOUR : `QQD_LANES_ONE);
  assign byteDone = sclkRise & bitSum[3];
  assign shNew    = lanes4 ? {sh_r[3:0], ioIn} : {sh_r[6:0], ioIn[0]};
  assign opDone   = byteDone & (st_r == ST_OPC);

  // Next state of the decoder
  always_comb
  begin
    // Held state keeps its value, pulses default low
    {cmd_nxt, sh_nxt, srByte_nxt, rdByte_nxt, pgmData_nxt}    = {cmd_r, sh_r, srByte_r, rdByte_r, pgmData_r};
    {bitCnt_nxt, byteCnt_nxt, nibLo_nxt, ioOut_nxt, ioOe_nxt} = {bitCnt_r, byteCnt_r, nibLo_r, ioOut_r, ioOe_r};
    {addr_nxt, pgmAddr_nxt}                                   = {addr_r, pgmAddr_r};
    st_nxt          = st_r;
    statusUpper_nxt = statusUpper_r;
    vsrWe_nxt       = vsrWe_r;
    {statusWr_nxt, rdReq_nxt, pgmStb_nxt, pgmDone_nxt, pgmAbort_nxt} = '0;
    if (sclkRise)
    begin
      sh_nxt     = shNew;
      bitCnt_nxt = bitSum[2:0];
    end
    // Byte count saturates so long bursts cannot wrap back to a valid count
    if (byteDone && byteCnt_r != 2'h3)
      byteCnt_nxt = byteCnt_r + 2'h1;
    case (st_r)
      ST_OPC:
        if (opDone)
        begin
          cmd_nxt     = shNew;
          byteCnt_nxt = 2'h0;
          if (busy && shNew != `QQD_OP_SUP_RD)
            st_nxt = ST_IGN;
          else if (qpiMode)
          begin
            case (shNew)
              `QQD_OP_VSRWE:  st_nxt = ST_HOLD;
              `QQD_OP_SUP_RD: st_nxt = ST_SRRD;
              `QQD_OP_SUP_WR: st_nxt = ST_SRWR;
              default:        st_nxt = ST_IGN;
            endcase
          end
          else
          begin
            case (shNew)
              `QQD_OP_QOREAD: st_nxt = ST_ADDR;
              `QQD_OP_QPROG:  st_nxt = ST_ADDR;
              default:        st_nxt = ST_IGN;
            endcase
          end
        end
      ST_ADDR:
        if (byteDone)
        begin
          addr_nxt = {addr_r[ADDR_W-9:0], shNew};
          if (byteCnt_r == LAST_ADDR)
          begin
            byteCnt_nxt = 2'h0;
            st_nxt      = (cmd_r == `QQD_OP_QOREAD) ? ST_DUMMY : ST_WDATA;
          end
        end
      // One dummy byte, then fetch the first data byte
      ST_DUMMY:
        if (byteDone)
        begin
          st_nxt    = ST_RDATA;
          rdReq_nxt = 1'b1;
          nibLo_nxt = 1'b0;
        end
      // High nibble first; low nibble comes from the captured copy
      ST_RDATA:
        if (sclkFall)
        begin
          ioOe_nxt  = 4'hf;
          nibLo_nxt = ~nibLo_r;
          if (!nibLo_r)
          begin
            ioOut_nxt  = rdData[7:4];
            rdByte_nxt = rdData;
          end
          else
          begin
            ioOut_nxt = rdByte_r[3:0];
            addr_nxt  = addr_r + 1'b1;
            rdReq_nxt = 1'b1;
          end
        end
      ST_WDATA:
        if (byteDone)
        begin
          pgmStb_nxt  = 1'b1;
          pgmData_nxt = shNew;
          pgmAddr_nxt = addr_r;
          addr_nxt    = addr_r + 1'b1;
        end
      // Status stays readable during busy, repeated while clocked
      ST_SRRD:
        if (sclkFall)
        begin
          ioOe_nxt  = 4'hf;
          nibLo_nxt = ~nibLo_r;
          ioOut_nxt = nibLo_r ? statusUpper_r[3:0] : statusUpper_r[7:4];
        end
      ST_SRWR:
        if (byteDone && byteCnt_r == 2'h0)
          srByte_nxt = shNew;
      default:
        ;
    endcase
    // Completion only on a whole byte boundary
    if (csRise)
    begin
      case (st_r)
        ST_HOLD:
          if (byteCnt_r == 2'h0 && bitCnt_r == 3'h0)
            vsrWe_nxt = 1'b1;
        ST_SRWR:
          if (byteCnt_r == 2'h1 && bitCnt_r == 3'h0)
          begin
            statusUpper_nxt = srByte_r;
            statusWr_nxt    = 1'b1;
            vsrWe_nxt       = 1'b0;
          end
        ST_WDATA:
          if (byteCnt_r != 2'h0 && bitCnt_r == 3'h0)
            pgmDone_nxt = 1'b1;
          else
            pgmAbort_nxt = 1'b1;
        ST_ADDR:
          pgmAbort_nxt = (cmd_r == `QQD_OP_QPROG);
        default:
          ;
      endcase
    end
    // Chip select high ends any instruction and releases the lines
    if (csN)
    begin
      st_nxt      = ST_OPC;
      bitCnt_nxt  = 3'h0;
      byteCnt_nxt = 2'h0;
      nibLo_nxt   = 1'b0;
      ioOe_nxt    = 4'h0;
    end
  end

  // Decoder registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r          <= ST_OPC;
      csPrev_r      <= 1'b1;
      sclkPrev_r    <= 1'b0;
      {cmd_r, sh_r, srByte_r, rdByte_r, pgmData_r}    <= '0;
      {bitCnt_r, byteCnt_r, nibLo_r, ioOut_r, ioOe_r} <= '0;
      {addr_r, pgmAddr_r}                             <= '0;
      statusUpper_r <= `QQD_STATUS_RST;
      {statusWr_r, vsrWe_r, rdReq_r}                  <= '0;
      {pgmStb_r, pgmDone_r, pgmAbort_r}               <= '0;
    end
    else
    begin
      st_r          <= st_nxt;
      csPrev_r      <= csN;
      sclkPrev_r    <= sclk;
      {cmd_r, sh_r, srByte_r, rdByte_r, pgmData_r}    <= {cmd_nxt, sh_nxt, srByte_nxt, rdByte_nxt, pgmData_nxt};
      {bitCnt_r, byteCnt_r, nibLo_r, ioOut_r, ioOe_r} <= {bitCnt_nxt, byteCnt_nxt, nibLo_nxt, ioOut_nxt, ioOe_nxt};
      {addr_r, pgmAddr_r}                             <= {addr_nxt, pgmAddr_nxt};
      statusUpper_r <= statusUpper_nxt;
      {statusWr_r, vsrWe_r, rdReq_r}                  <= {statusWr_nxt, vsrWe_nxt, rdReq_nxt};
      {pgmStb_r, pgmDone_r, pgmAbort_r}               <= {pgmStb_nxt, pgmDone_nxt, pgmAbort_nxt};
    end
  end

  // Outputs straight from flops
  assign ioOut       = ioOut_r;
  assign ioOe        = ioOe_r;
  assign statusUpper = statusUpper_r;
  assign statusWr    = statusWr_r;
  assign vsrWe       = vsrWe_r;
  assign rdReq       = rdReq_r;
  assign rdAddr      = addr_r;
  assign pgmStb      = pgmStb_r;
  assign pgmAddr     = pgmAddr_r;
  assign pgmData     = pgmData_r;
  assign pgmDone     = pgmDone_r;
  assign pgmAbort    = pgmAbort_r;

  // Checks on the decoder
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  qread_drive_a: assert property ((st_r == ST_RDATA) && sclkFall |=> ioOe_r == 4'hf)
    else $error("quad read data not driven on four lines");
  prog_strobe_a: assert property (pgmStb_r |-> $past(st_r) == ST_WDATA && pgmData_r == $past(shNew))
    else $error("program strobe outside data phase");
  qpi_opcode_a: assert property (qpiMode && !busy && (st_r == ST_OPC) && sclkRise && bitCnt_r == 3'h4
                                 |=> st_r != ST_OPC || csN)
    else $error("QPI opcode not taken after two clocks");
  vsr_enable_a: assert property ($rose(vsrWe_r) |-> $past(cmd_r) == `QQD_OP_VSRWE && $past(csRise))
    else $error("volatile write enable without its opcode");
  status_read_a: assert property ((st_r == ST_SRRD) && sclkFall && !nibLo_r |=> ioOut_r == statusUpper_r[7:4])
    else $error("status upper nibble wrong");
  status_write_a: assert property (statusWr_r |-> statusUpper_r == $past(srByte_r) && $past(st_r) == ST_SRWR)
    else $error("status write value wrong");
  cs_end_a: assert property (csRise |=> st_r == ST_OPC && ioOe_r == 4'h0)
    else $error("chip select rise did not end instruction");
  partial_byte_a: assert property (csRise && bitCnt_r != 3'h0 |=> !pgmDone_r && !statusWr_r && !$rose(vsrWe_r))
    else $error("partial byte write took effect");
  busy_ignore_a: assert property (opDone && busy && shNew != `QQD_OP_SUP_RD |=> st_r == ST_IGN || csN)
    else $error("instruction accepted while busy");
  mode_ignore_a: assert property (opDone && !busy && !qpiMode && shNew == `QQD_OP_SUP_WR |=> st_r == ST_IGN || csN)
    else $error("opcode accepted in wrong line mode");

  prog_done_c: cover property (pgmDone_r);
  status_wr_c: cover property (statusWr_r);
  qread_two_c: cover property (rdReq_r ##[1:64] rdReq_r);
  abort_c:     cover property (pgmAbort_r);

endmodule

// File: verilog/qqd_regs.svh
// Opcodes, counts and reset values of the quad/QPI command decoder
`ifndef QQD_REGS_SVH
`define QQD_REGS_SVH
`define QQD_OP_QOREAD  8'h6b
`define QQD_OP_QPROG   8'h33
`define QQD_OP_VSRWE   8'h50
`define QQD_OP_SUP_RD  8'h35
`define QQD_OP_SUP_WR  8'h31
`define QQD_ADDR_BITS  24
`define QQD_STATUS_RST 8'h00
`define QQD_LANES_ONE  4'h1
`define QQD_LANES_FOUR 4'h4
`endif

// File: verilog/qqd_pkg.sv
// Types of the quad/QPI command decoder
package qqd_pkg;
  typedef enum logic [3:0] {ST_OPC, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA, ST_SRRD, ST_SRWR, ST_HOLD, ST_IGN} qqd_state_t;
endpackage

// File: dv/qqd_host_model.sv
// Host controller model that drives chip select, serial clock and lines
`timescale 1ns/1ps
module qqd_host_model
(
  // Clock
  input  wire logic       mclk,
  // Host pins
  output logic            csN,
  output logic            sclk,
  output logic [3:0]      ioIn,
  input  wire logic [3:0] ioOut
);
  // Clock stands low and chip select high outside frames
  initial
  begin
    csN  = 1'b1;
    sclk = 1'b0;
    ioIn = 4'h0;
  end

  // One serial clock: fall, then rise with data; lines read late in the high phase
  task automatic beat(input logic [3:0] d, output logic [3:0] q);
    @(negedge mclk) sclk = 1'b0;
    repeat (2) @(negedge mclk);
    ioIn = d;
    sclk = 1'b1;
    repeat (2) @(negedge mclk);
    q = ioOut;
  endtask

  // Single-line byte, MSB first; unused lines toggle so they carry nothing
  task automatic ser(input logic [7:0] b);
    logic [3:0] q;
    for (int i = 7; i >= 0; i--)
      beat({{3{~b[i]}}, b[i]}, q);
  endtask

  // Four-line byte, high nibble first, two clocks
  task automatic quad(input logic [7:0] b, output logic [7:0] r);
    beat(b[7:4], r[7:4]);
    beat(b[3:0], r[3:0]);
  endtask

  task automatic start();
    @(negedge mclk) csN = 1'b0;
  endtask

  // Clock low first, then chip select high; released lines show the inverse
  task automatic stop();
    @(negedge mclk) sclk = 1'b0;
    repeat (2) @(negedge mclk);
    csN  = 1'b1;
    ioIn = ~ioIn;
    repeat (3) @(negedge mclk);
  endtask
endmodule

// File: dv/qqd_decoder_bench.sv
// Self-checking bench of the quad/QPI command decoder
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module qqd_decoder_bench;
  import qqd_pkg::*;
  logic        mclk, rst_n, csN, sclk, qpiMode, busy;
  logic [3:0]  ioIn, ioOut, ioOe;
  logic [7:0]  statusUpper, rdData, pgmData, r, v;
  logic        statusWr, vsrWe, rdReq, pgmStb, pgmDone, pgmAbort, sawOe;
  logic [23:0] rdAddr, pgmAddr;
  logic [23:0] sA[$];
  logic [7:0]  sD[$];
  int          failures, n_compared, nDone, nAbort, nSw, nRd;

  qqd_host_model qqd_host_model_inst (.mclk(mclk), .csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut));
  qqd_decoder qqd_decoder_inst (.mclk(mclk), .rst_n(rst_n), .csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut),
    .ioOe(ioOe), .qpiMode(qpiMode), .busy(busy), .statusUpper(statusUpper), .statusWr(statusWr), .vsrWe(vsrWe),
    .rdReq(rdReq), .rdAddr(rdAddr), .rdData(rdData), .pgmStb(pgmStb), .pgmAddr(pgmAddr), .pgmData(pgmData),
    .pgmDone(pgmDone), .pgmAbort(pgmAbort));

  // Array contents are a fixed function of the address
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Array model answers half a cycle after the address moves
  always @(negedge mclk) rdData <= mem(rdAddr);

  // Pulse monitor, sampled mid-cycle where outputs are settled; counters are cleared by each scenario
  always @(negedge mclk)
  begin
    if (pgmStb) begin sA.push_back(pgmAddr); sD.push_back(pgmData); end
    nRd    += rdReq;
    nDone  += pgmDone;
    nAbort += pgmAbort;
    nSw    += statusWr;
    sawOe  |= |ioOe;
  end

  task automatic clr();
    sA.delete();
    sD.delete();
    {nDone, nAbort, nSw, nRd, sawOe} = '0;
  endtask

  // QPI frame: opcode, then n bytes exchanged; r holds the last byte read
  task automatic qpi(input logic [7:0] op, input logic [7:0] d, input int n);
    clr();
    qqd_host_model_inst.start();
    qqd_host_model_inst.quad(op, r);
    for (int i = 0; i < n; i++)
      qqd_host_model_inst.quad(d, r);
    qqd_host_model_inst.stop();
  endtask

  // SPI-side quad read of three bytes across the address increment
  task automatic qread(input logic [23:0] a);
    clr();
    qqd_host_model_inst.start();
    qqd_host_model_inst.ser(`QQD_OP_QOREAD);
    for (int i = 2; i >= 0; i--)
      qqd_host_model_inst.ser(a[8*i+:8]);
    qqd_host_model_inst.ser(8'($urandom));
    for (int i = 0; i < 3; i++)
    begin
      qqd_host_model_inst.quad(8'h00, r);
      `CHK(r, mem(24'(a + i)))
      `CHK(ioOe, 4'hf)
    end
    qqd_host_model_inst.stop();
    `CHK(ioOe, 4'h0)
    `CHK(nRd, 4)
  endtask

  // Quad program of two bytes, optionally cut after half a byte
  task automatic qprog(input logic [23:0] a, input logic [7:0] d0, input logic [7:0] d1, input bit cut);
    clr();
    qqd_host_model_inst.start();
    qqd_host_model_inst.ser(`QQD_OP_QPROG);
    for (int i = 2; i >= 0; i--)
      qqd_host_model_inst.ser(a[8*i+:8]);
    qqd_host_model_inst.quad(d0, r);
    qqd_host_model_inst.quad(d1, r);
    if (cut)
      qqd_host_model_inst.beat(d0[7:4], r[3:0]);
    qqd_host_model_inst.stop();
    `CHK(sA.size(), 2)
    `CHK(sA[0], a)
    `CHK(sD[0], d0)
    `CHK(sD[1], d1)
    `CHK(sA[1], 24'(a + 1))
    `CHK(nDone, cut ? 0 : 1)
    `CHK(nAbort, cut ? 1 : 0)
  endtask

  // Single-line frame of opcode and one byte, for opcodes of the other mode
  task automatic spi(input logic [7:0] op, input logic [7:0] d);
    clr();
    qqd_host_model_inst.start();
    qqd_host_model_inst.ser(op);
    qqd_host_model_inst.ser(d);
    qqd_host_model_inst.stop();
  endtask

  task automatic results();
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run of some 2k cycles
  initial
  begin
    #100us;
    failures++;
    results();
  end

  initial
  begin
    {rst_n, qpiMode, busy} = '0;
    void'($urandom(38));
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    `CHK(statusUpper, `QQD_STATUS_RST)
    // QPI status path: enable, write, read back
    qpiMode = 1'b1;
    qpi(`QQD_OP_VSRWE, 8'h00, 0);
    `CHK(vsrWe, 1'b1)
    v = 8'($urandom);
    qpi(`QQD_OP_SUP_WR, v, 1);
    `CHK(statusUpper, v)
    `CHK(nSw, 1)
    `CHK(vsrWe, 1'b0)
    qpi(`QQD_OP_SUP_RD, 8'h00, 2);
    `CHK(r, v)
    // Busy: write ignored, status read still served
    busy = 1'b1;
    qpi(`QQD_OP_SUP_WR, ~v, 1);
    `CHK(nSw, 0)
    qpi(`QQD_OP_SUP_RD, 8'h00, 1);
    `CHK(r, v)
    busy = 1'b0;
    // Status write cut after half a byte is discarded
    clr();
    qqd_host_model_inst.start();
    qqd_host_model_inst.quad(`QQD_OP_SUP_WR, r);
    qqd_host_model_inst.beat(~v[7:4], r[3:0]);
    qqd_host_model_inst.stop();
    `CHK(statusUpper, v)
    // Opcodes of the other mode produce nothing
    qpi(`QQD_OP_QOREAD, 8'h00, 6);
    `CHK(sawOe, 1'b0)
    qpiMode = 1'b0;
    spi(`QQD_OP_SUP_RD, 8'h00);
    `CHK(sawOe, 1'b0)
    spi(`QQD_OP_SUP_WR, ~v);
    `CHK(nSw, 0)
    `CHK(statusUpper, v)
    // SPI-side quad reads and programs, random with a carry corner
    qread(24'h0000ff);
    for (int i = 0; i < 4; i++)
      qread(24'($urandom));
    qprog(24'($urandom), 8'($urandom), 8'($urandom), 1'b0);
    qprog(24'($urandom), 8'($urandom), 8'($urandom), 1'b1);
    results();
  end
endmodule
